/* core/ext_int_consts.svh */
// offsets, reset values and field positions for the external interrupt sense block
`ifndef EXT_INT_CONSTS_SVH
`define EXT_INT_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_PRIO0    6'h25
`define IDX_PRIO1    6'h26
`define IDX_PRIO2    6'h27
`define IDX_PRIO3    6'h28
`define IDX_SENSE    6'h29
`define IDX_TOP      6'h2a
`define IDX_STAT     6'h2b
`define IDX_MASK     6'h2c

// reset values
`define PRIO_RST     8'hff
`define SENSE_RST    8'h00
`define TOP_RST      8'h00
`define TOP_BIT_RST  1'b0
`define EVT_RST      5'h00

// priority fields: the level 0 code is refused, register 3 upper nibble is fixed
`define PRIO_HOLD    2'b10
`define PRIO3_FIXED  8'hf0

// field layout
`define SEL_W        2
`define TOP_SEL_BIT  1
`define TOP_EN_BIT   0
`define TOP_LINE     4
`define PIN_IDLE     5'h1f

// bus answers
`define RESP_OKAY    2'b00
`define RESP_DECERR  2'b11

`endif

/* core/ext_int_pkg.sv */
// types shared by the external interrupt sense block
package ext_int_pkg;

	// sensitivity selector codes, declared in encoding order
	typedef enum logic [1:0] {
		SENSE_FALL_LOW,
		SENSE_RISE,
		SENSE_FALL,
		SENSE_BOTH
	} sense_e;

	// line configuration carried together
	typedef struct packed {
		logic [7:0] sense;     // four two-bit selectors
		logic       edge_sel;  // top pin: 0 falling, 1 rising
		logic       enable;    // top pin recognition on
	} line_cfg_s;

endpackage

/* core/external_interrupt_sense.sv */
// external interrupt sensitivity control with its register file on axi4-lite
//
// Function
// - four lines, each own two-bit sensitivity selector
// - codes: fall+low, rise, fall, both edges
// - selectors at bits 7:6, 5:4, 3:2, 1:0
// - selector write only accepted at mask level 3
// - changed selector value clears that line's pending
// - top edge select bit 1: fall 0, rise 1
// - top edge select writable only while disabled
// - top enable bit 0 gates top pin events
// - clearing top enable may give one request
// - map 25h-28h ones, 29h/2Ah zero
// - priority fields refuse code 10, keep old
// - top priority bits stored, unused
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ext_int_consts.svh"

module external_interrupt_sense
	import ext_int_pkg::*;
#(
	parameter int ADDR_W = 8  // byte address width
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	input  wire logic [3:0]          ext_line_pin,
	input  wire logic                top_level_interrupt,
	input  wire logic                cpu_mask_hi,
	input  wire logic                cpu_mask_lo,
	input  wire logic [3:0]          ext_service,
	input  wire logic                top_service,
	output logic [3:0]               ext_pending,
	output logic                     top_pending,
	output logic [25:0]              soft_prio,
	output logic                     irq
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (ADDR_W != 8) begin : g_bad_addr
		$error("address width must be 8");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [4:0]        pin_s1_ff;     // first stage, read by stage two only
	logic [4:0]        pin_s2_ff;     // second stage
	logic [4:0]        pin_s3_ff;     // third stage
	logic [4:0]        lvl_ff;        // filtered pin level
	logic [4:0]        lvl_q_ff;      // level one cycle back
	logic [4:0]        rise;          // rising edge seen
	logic [4:0]        fall;          // falling edge seen
	logic [4:0]        evt;           // request events, bit 4 is top pin
	logic [4:0]        pend_ff;       // pending requests
	logic [4:0]        stat_ff;       // sticky status
	logic [4:0]        mask_ff;       // interrupt mask
	logic              irq_ff;        // registered interrupt
	logic [3:0][7:0]   prio_ff;       // priority registers
	line_cfg_s         cfg_ff;        // sense and top control
	logic              aw_hold_ff;    // write address held
	logic              w_hold_ff;     // write data held
	logic [5:0]        aw_idx_ff;     // held write index
	logic [7:0]        wd_ff;         // held low write byte
	logic              wb0_ff;        // held lane 0 strobe
	logic              bvalid_ff;     // write answer
	logic [1:0]        bresp_ff;      // write answer code
	logic              rvalid_ff;     // read answer
	logic [31:0]       rdata_ff;      // read data
	logic [1:0]        rresp_ff;      // read answer code
	logic              wr_go;         // both halves held
	logic              wr_en;         // byte 0 write this cycle
	logic              sense_ok;      // selector write allowed
	logic [3:0]        sel_chg;       // selector changed by write
	logic              top_clr_evt;   // enable cleared while armed
	logic [7:0]        rd_byte;       // read mux result
	logic              rd_hit;        // read index mapped
	logic [5:0]        ar_idx;        // read index

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// decides whether a line fires for its selector
	function automatic logic line_fire(input sense_e s, input logic r,
		input logic f, input logic l);
		logic v;
		v = 1'b0;
		unique case (s)
			SENSE_FALL_LOW: v = f | ~l;  // edge and held low level
			SENSE_RISE:     v = r;
			SENSE_FALL:     v = f;
			SENSE_BOTH:     v = r | f;
		endcase
		return v;
	endfunction

	// merges a priority write, the level 0 code keeps the old field
	function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
		input logic [7:0] new_v);
		logic [7:0] m;
		m = new_v;
		for (int k = 0; k < 4; k++) begin
			if (new_v[2*k+:2] == `PRIO_HOLD) begin
				m[2*k+:2] = old_v[2*k+:2];
			end
		end
		return m;
	endfunction

	// index is one of the mapped registers
	function automatic logic idx_mapped(input logic [5:0] i);
		return (i >= `IDX_PRIO0) && (i <= `IDX_MASK);
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	// three stages; idle high avoids a false fall after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= `PIN_IDLE;
			pin_s2_ff <= `PIN_IDLE;
			pin_s3_ff <= `PIN_IDLE;
		end else begin
			pin_s1_ff <= {top_level_interrupt, ext_line_pin};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	// level moves only when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_ff   <= `PIN_IDLE;
			lvl_q_ff <= `PIN_IDLE;
		end else begin
			lvl_ff   <= (~(pin_s2_ff ^ pin_s3_ff) & pin_s3_ff)
				| ((pin_s2_ff ^ pin_s3_ff) & lvl_ff);
			lvl_q_ff <= lvl_ff;
		end
	end

	assign rise = lvl_ff & ~lvl_q_ff;
	assign fall = ~lvl_ff & lvl_q_ff;

	// ------------------------------------------------------------
	// event generation
	// ------------------------------------------------------------
	// each line applies its own selector
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			evt[i] = line_fire(sense_e'(cfg_ff.sense[`SEL_W*i+:`SEL_W]),
				rise[i], fall[i], lvl_ff[i]);
		end
		// top pin only while enabled, plus the clear artefact
		evt[`TOP_LINE] = (cfg_ff.enable & (cfg_ff.edge_sel ?
			rise[`TOP_LINE] : fall[`TOP_LINE])) | top_clr_evt;
	end

	// clearing enable while the pin sits past its edge gives one request;
	// software that cannot bond the pin keeps enable low to avoid it
	assign top_clr_evt = wr_en && (aw_idx_ff == `IDX_TOP) && cfg_ff.enable
		&& !wd_ff[`TOP_EN_BIT]
		&& (lvl_ff[`TOP_LINE] == cfg_ff.edge_sel);

	// ------------------------------------------------------------
	// pending requests
	// ------------------------------------------------------------
	// a new event beats a service or selector-change clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_ff <= `EVT_RST;
		end else begin
			pend_ff <= evt | (pend_ff & ~{top_service, ext_service | sel_chg});
		end
	end

	assign ext_pending = pend_ff[3:0];
	assign top_pending = pend_ff[`TOP_LINE];

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	// address and data taken in either order, one write in flight
	assign awready = !aw_hold_ff && !bvalid_ff;
	assign wready  = !w_hold_ff && !bvalid_ff;
	assign wr_go   = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign wr_en   = wr_go && wb0_ff;  // only lane 0 carries register bits

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			aw_idx_ff  <= '0;
		end else if (awvalid && awready) begin
			aw_hold_ff <= 1'b1;
			aw_idx_ff  <= awaddr[ADDR_W-1:2];
		end else if (wr_go) begin
			aw_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_ff <= 1'b0;
			wd_ff     <= '0;
			wb0_ff    <= 1'b0;
		end else if (wvalid && wready) begin
			w_hold_ff <= 1'b1;
			wd_ff     <= wdata[7:0];
			wb0_ff    <= wstrb[0];
		end else if (wr_go) begin
			w_hold_ff <= 1'b0;
		end
	end

	// response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= idx_mapped(aw_idx_ff) ? `RESP_OKAY : `RESP_DECERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;

	// ------------------------------------------------------------
	// register updates
	// ------------------------------------------------------------
	// selectors move only at cpu mask level 3
	assign sense_ok = wr_en && (aw_idx_ff == `IDX_SENSE)
		&& cpu_mask_hi && cpu_mask_lo;

	// a differing new selector drops that line's pending request
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sel_chg[i] = sense_ok && (wd_ff[`SEL_W*i+:`SEL_W]
				!= cfg_ff.sense[`SEL_W*i+:`SEL_W]);
		end
	end

	// sense selectors and top control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff.sense    <= `SENSE_RST;
			cfg_ff.edge_sel <= `TOP_BIT_RST;  // single bits, no width loss
			cfg_ff.enable   <= `TOP_BIT_RST;
		end else begin
			if (sense_ok) begin
				cfg_ff.sense <= wd_ff;
			end
			if (wr_en && aw_idx_ff == `IDX_TOP) begin
				cfg_ff.enable <= wd_ff[`TOP_EN_BIT];
				// edge select frozen while recognition is on
				if (!cfg_ff.enable) begin
					cfg_ff.edge_sel <= wd_ff[`TOP_SEL_BIT];
				end
			end
		end
	end

	// priority registers, reset to all ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prio_ff <= {4{`PRIO_RST}};
		end else if (wr_en) begin
			for (int r = 0; r < 3; r++) begin
				if (aw_idx_ff == `IDX_PRIO0 + 6'(r)) begin
					prio_ff[r] <= prio_merge(prio_ff[r], wd_ff);
				end
			end
			if (aw_idx_ff == `IDX_PRIO3) begin
				prio_ff[3] <= prio_merge(prio_ff[3], wd_ff) | `PRIO3_FIXED;
			end
		end
	end

	// top pin priority bits are kept but left off the output
	assign soft_prio = {prio_ff[3][3:0], prio_ff[2], prio_ff[1],
		prio_ff[0][7:2]};

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	// sticky, write one to clear, a same-cycle event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_ff <= `EVT_RST;
			mask_ff <= `EVT_RST;
		end else begin
			if (wr_en && aw_idx_ff == `IDX_STAT) begin
				stat_ff <= evt | (stat_ff & ~wd_ff[4:0]);
			end else begin
				stat_ff <= evt | stat_ff;
			end
			if (wr_en && aw_idx_ff == `IDX_MASK) begin
				mask_ff <= wd_ff[4:0];
			end
		end
	end

	// level output, registered to keep it glitch free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	assign irq = irq_ff;

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign ar_idx  = araddr[ADDR_W-1:2];
	assign arready = !rvalid_ff;

	// read mux; unmapped indices answer decode error and zero
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = '0;
		unique case (ar_idx)
			`IDX_PRIO0: rd_byte = prio_ff[0];
			`IDX_PRIO1: rd_byte = prio_ff[1];
			`IDX_PRIO2: rd_byte = prio_ff[2];
			`IDX_PRIO3: rd_byte = prio_ff[3];
			`IDX_SENSE: rd_byte = cfg_ff.sense;
			`IDX_TOP:   rd_byte = {6'h00, cfg_ff.edge_sel, cfg_ff.enable};
			`IDX_STAT:  rd_byte = {3'h0, stat_ff};
			`IDX_MASK:  rd_byte = {3'h0, mask_ff};
			default:    rd_hit  = 1'b0;
		endcase
	end

	// data captured when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, rd_byte};
			rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign rvalid = rvalid_ff;
	assign rdata  = rdata_ff;
	assign rresp  = rresp_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_pin0_high;
		$rose(ext_line_pin[0]) ##1 ext_line_pin[0] [*4];
	endsequence

	property p_sync_level;
		@(posedge aclk) disable iff (!aresetn)
		s_pin0_high |-> lvl_ff[0];
	endproperty
	a_sync_level: assert property (p_sync_level) else $error("pin level late");

	property p_sense_locked;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && aw_idx_ff == `IDX_SENSE && !(cpu_mask_hi && cpu_mask_lo))
		|=> $stable(cfg_ff.sense);
	endproperty
	a_sense_locked: assert property (p_sense_locked) else $error("sense moved");

	property p_sel_clear;
		@(posedge aclk) disable iff (!aresetn)
		(sel_chg[0] && !evt[0] && !ext_service[0]) |=> !pend_ff[0];
	endproperty
	a_sel_clear: assert property (p_sel_clear) else $error("pending kept");

	property p_edge_frozen;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && aw_idx_ff == `IDX_TOP && cfg_ff.enable) |=> $stable(cfg_ff.edge_sel);
	endproperty
	a_edge_frozen: assert property (p_edge_frozen) else $error("edge sel moved");

	property p_rise_only;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_ff.sense[3:2] == SENSE_RISE && rise[1]) |=> pend_ff[1] && stat_ff[1];
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("rise missed");

	property p_low_level;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_ff.sense[5:4] == SENSE_FALL_LOW && !lvl_ff[2]) |=> pend_ff[2];
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level missed");

	property p_top_off;
		@(posedge aclk) disable iff (!aresetn)
		(!cfg_ff.enable && !top_clr_evt && !pend_ff[`TOP_LINE]) |=> !pend_ff[`TOP_LINE];
	endproperty
	a_top_off: assert property (p_top_off) else $error("top fired disabled");

	property p_prio_hold;
		@(posedge aclk) disable iff (!aresetn)
		(wr_en && aw_idx_ff == `IDX_PRIO1 && wd_ff[7:6] == `PRIO_HOLD)
		|=> $stable(prio_ff[1][7:6]);
	endproperty
	a_prio_hold: assert property (p_prio_hold) else $error("level 0 stored");

	property p_top_reserved;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && ar_idx == `IDX_TOP) |=> rdata[7:2] == 6'h00;
	endproperty
	a_top_reserved: assert property (p_top_reserved) else $error("reserved set");

endmodule
`default_nettype wire

/* dv/pin_cpu_model.sv */
// far side model: external interrupt pins and the cpu interrupt mask bits
`timescale 1ns/10ps
`default_nettype none

module pin_cpu_model (
	input  wire logic       aclk,                 // block clock
	input  wire logic       aresetn,              // sync reset, active low
	input  wire logic [3:0] pin_req,              // wanted line levels
	input  wire logic       top_req,              // wanted top pin level
	input  wire logic [1:0] level_req,            // wanted cpu mask level
	output logic      [3:0] ext_line_pin,         // external lines
	output logic            top_level_interrupt,  // top pin, bonded here
	output logic            cpu_mask_hi,          // mask bit high
	output logic            cpu_mask_lo           // mask bit low
);
	// ------------------------------------------------------------
	// pins: idle high, as with pull-ups, so no false fall at start
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_line_pin        <= 4'hf;
			top_level_interrupt <= 1'b1;
		end else begin
			ext_line_pin        <= pin_req;
			top_level_interrupt <= top_req;
		end
	end

	// ------------------------------------------------------------
	// mask level: software sits at level 3 around selector changes
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{cpu_mask_hi, cpu_mask_lo} <= 2'b11;
		end else begin
			{cpu_mask_hi, cpu_mask_lo} <= level_req;
		end
	end
endmodule

`default_nettype wire

/* dv/external_interrupt_sense_tb_top.sv */
// self-checking bench for the external interrupt sense block
`timescale 1ns/10ps
`default_nettype none
`include "ext_int_consts.svh"

module external_interrupt_sense_tb_top
	import ext_int_pkg::*;
;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	logic        aclk, aresetn;                  // clock and reset
	logic [7:0]  awaddr, araddr;                 // byte addresses
	logic        awvalid, wvalid, bready;        // write channels
	logic        arvalid, rready;                // read channels
	logic        awready, wready, bvalid;        // write answers
	logic        arready, rvalid;                // read answers
	logic [31:0] wdata, rdata;                   // bus data
	logic [3:0]  wstrb, pin_req, ext_service;    // strobes, pins, service
	logic [1:0]  bresp, rresp, level_req;        // responses, mask level
	logic [3:0]  ext_line_pin, ext_pending;      // lines and pendings
	logic        top_pin, top_req, top_service;  // top pin side
	logic        mask_hi, mask_lo, top_pending;  // mask bits, top pending
	logic        irq;                            // interrupt output
	logic [25:0] soft_prio;                      // priority fields out
	logic [31:0] seed;                           // xorshift state
	logic [31:0] d;                              // read data
	logic [1:0]  r;                              // response code
	logic [7:0]  p [4];                          // priority shadows
	logic [7:0]  v;                              // random byte
	int          fails, n_compared, cyc, i, k, l, c;

	// ------------------------------------------------------------
	// clock, timeout
	// ------------------------------------------------------------
	initial aclk = 1'b0;
	always #2.5 aclk = ~aclk;
	// a hang counts as a mismatch and closes the run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// design and far side
	// ------------------------------------------------------------
	external_interrupt_sense u_external_interrupt_sense (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_line_pin(ext_line_pin),
		.top_level_interrupt(top_pin), .cpu_mask_hi(mask_hi), .cpu_mask_lo(mask_lo),
		.ext_service(ext_service), .top_service(top_service),
		.ext_pending(ext_pending), .top_pending(top_pending),
		.soft_prio(soft_prio), .irq(irq));
	pin_cpu_model u_pin_cpu_model (
		.aclk(aclk), .aresetn(aresetn), .pin_req(pin_req), .top_req(top_req),
		.level_req(level_req), .ext_line_pin(ext_line_pin),
		.top_level_interrupt(top_pin), .cpu_mask_hi(mask_hi), .cpu_mask_lo(mask_lo));

	// ------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// a field written with the level 0 code keeps its old value
	function automatic logic [7:0] prio_merge(input logic [7:0] o, input logic [7:0] n);
		logic [7:0] res;
		for (int f = 0; f < 4; f++)
			res[2*f+:2] = (n[2*f+:2] == `PRIO_HOLD) ? o[2*f+:2] : n[2*f+:2];
		return res;
	endfunction
	// whether a pin edge raises a request under a selector code
	function automatic logic exp_edge(input logic [1:0] code, input logic fall);
		if (fall)
			return code != SENSE_RISE;
		return code == SENSE_RISE || code == SENSE_BOTH;
	endfunction

	// ------------------------------------------------------------
	// compare, verdict
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// bus tasks: entered just after a rising edge
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [5:0] idx, input logic [7:0] dv, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		awaddr  <= {idx, 2'b00};
		wdata   <= {24'h0, dv};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				rs = bresp;
				done = 1'b1;
			end
		end
	endtask
	task automatic axi_rd(input logic [5:0] idx, output logic [31:0] dv, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				dv = rdata;
				rs = rresp;
				done = 1'b1;
			end
		end
	endtask
	task automatic wrc(input logic [5:0] idx, input logic [7:0] dv);
		logic [1:0] rs;
		axi_wr(idx, dv, rs);
		chk(32'(rs), 32'(`RESP_OKAY));
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] dv;
		logic [1:0]  rs;
		axi_rd(idx, dv, rs);
		chk(dv, 32'(e));
		chk(32'(rs), 32'(`RESP_OKAY));
	endtask
	// pin moves, then enough edges for sync and pending to land
	task automatic pin(input int ln, input logic lv);
		if (ln == `TOP_LINE)
			top_req <= lv;
		else
			pin_req[ln] <= lv;
		repeat (8) @(posedge aclk);
	endtask
	task automatic svc();
		ext_service <= 4'hf;
		top_service <= 1'b1;
		@(posedge aclk);
		ext_service <= 4'h0;
		top_service <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic lvl(input logic [1:0] lv);
		level_req <= lv;
		repeat (2) @(posedge aclk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h15;
		// answer readies stay high, so back-to-back calls never retoggle them
		{aresetn, awvalid, wvalid, bready, arvalid, rready, top_service} = 7'h0a;
		{awaddr, araddr, wdata, wstrb, ext_service} = 56'h10;
		{pin_req, top_req, level_req} = 7'h7f;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// reset values, reserved and unmapped places
		for (i = 0; i < 4; i++)
			rdc(6'(`IDX_PRIO0 + i), `PRIO_RST);
		rdc(`IDX_SENSE, `SENSE_RST);
		rdc(`IDX_TOP, `TOP_RST);
		chk(32'(soft_prio), 32'h3ffffff);
		axi_rd(6'h30, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(`RESP_DECERR));
		axi_wr(6'h3f, 8'h5a, r);
		chk(32'(r), 32'(`RESP_DECERR));
		// priority fields: refused code, fixed nibble, random writes
		for (i = 0; i < 4; i++)
			p[i] = `PRIO_RST;
		wrc(`IDX_PRIO1, 8'hcf);
		wrc(`IDX_PRIO1, 8'h64);
		rdc(`IDX_PRIO1, 8'h44);
		wrc(`IDX_PRIO1, 8'h80);
		rdc(`IDX_PRIO1, 8'h40);
		p[1] = 8'h40;
		wrc(`IDX_PRIO3, 8'h00);
		rdc(`IDX_PRIO3, 8'hf0);
		p[3] = 8'hf0;
		for (i = 0; i < 12; i++) begin
			k = int'(rnd() % 3);
			v = 8'(rnd());
			wrc(6'(`IDX_PRIO0 + k), v);
			p[k] = prio_merge(p[k], v);
			rdc(6'(`IDX_PRIO0 + k), p[k]);
		end
		chk(32'(soft_prio), 32'({p[3][3:0], p[2], p[1], p[0][7:2]}));
		// selector writes away from mask level 3 are ignored
		for (i = 0; i < 3; i++) begin
			lvl(2'(i));
			wrc(`IDX_SENSE, 8'(rnd()));
			rdc(`IDX_SENSE, `SENSE_RST);
		end
		lvl(2'b11);
		// every code on every line: edges and low level
		for (l = 0; l < 4; l++) begin
			for (c = 0; c < 4; c++) begin
				wrc(`IDX_SENSE, 8'(c << (2 * l)));
				rdc(`IDX_SENSE, 8'(c << (2 * l)));
				svc();
				pin(l, 1'b0);
				chk(32'(ext_pending), 32'(exp_edge(2'(c), 1'b1)) << l);
				svc();
				chk(32'(ext_pending[l]), 32'(c == 0));
				pin(l, 1'b1);
				chk(32'(ext_pending[l]), 32'(c == 0 || exp_edge(2'(c), 1'b0)));
				svc();
				chk(32'(ext_pending), 32'h0);
			end
		end
		// only a changed field clears its own pending
		wrc(`IDX_SENSE, 8'h08);
		pin(1, 1'b0);
		pin(1, 1'b1);
		wrc(`IDX_SENSE, 8'h08);
		wrc(`IDX_SENSE, 8'h09);
		chk(32'(ext_pending[1]), 32'h1);
		wrc(`IDX_SENSE, 8'h05);
		chk(32'(ext_pending[1]), 32'h0);
		// top pin: edge select locked while enabled
		wrc(`IDX_TOP, 8'hfe);
		rdc(`IDX_TOP, 8'h02);
		wrc(`IDX_TOP, 8'h03);
		wrc(`IDX_TOP, 8'h01);
		rdc(`IDX_TOP, 8'h03);
		pin(`TOP_LINE, 1'b0);
		chk(32'(top_pending), 32'h0);
		pin(`TOP_LINE, 1'b1);
		chk(32'(top_pending), 32'h1);
		svc();
		// clearing enable with the pin past its edge gives one request
		wrc(`IDX_TOP, 8'h02);
		chk(32'(top_pending), 32'h1);
		svc();
		pin(`TOP_LINE, 1'b0);
		pin(`TOP_LINE, 1'b1);
		chk(32'(top_pending), 32'h0);
		wrc(`IDX_TOP, 8'h01);
		rdc(`IDX_TOP, 8'h01);
		pin(`TOP_LINE, 1'b0);
		chk(32'(top_pending), 32'h1);
		pin(`TOP_LINE, 1'b1);
		wrc(`IDX_TOP, 8'h00);
		svc();
		// status, mask and the interrupt output
		wrc(`IDX_SENSE, 8'h20);
		wrc(`IDX_STAT, 8'h1f);
		rdc(`IDX_STAT, 8'h00);
		pin(2, 1'b0);
		rdc(`IDX_STAT, 8'h04);
		chk(32'(irq), 32'h0);
		wrc(`IDX_MASK, 8'h04);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h1);
		wrc(`IDX_STAT, 8'h04);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rdc(`IDX_STAT, 8'h00);
		// a write without lane 0 strobe leaves the register alone
		wstrb <= 4'h0;
		wrc(`IDX_MASK, 8'h00);
		wstrb <= 4'h1;
		rdc(`IDX_MASK, 8'h04);
		print_verdict();
	end
endmodule

`default_nettype wire
